// File: verilog/lna_gain_bias_trigger_regs.sv
`timescale 1ns/1ps
`default_nettype none
module lna_gain_bias_trigger_regs
  import lna_regs_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  input  wire logic                 sclk,
  input  wire logic                 link_rst,
  input  wire logic                 wr_valid,
  input  wire logic [7:0]           wr_addr,
  input  wire logic [7:0]           wr_data,
  input  wire logic [7:0]           wr_mask,
  input  wire logic                 usid_sel_pin,
  input  wire logic                 line_swap,
  output logic                      link_ready,
  output logic [7:0]                ctrl_shadow,
  output logic [7:0]                ctrl_active,
  output logic [NUM_TRIG-1:0]       trig_mask,
  output logic                      trig_enable,
  output logic [USID_W-1:0]         slave_id,
  output logic                      transfer_done,
  output logic                      amp_on,
  output logic [GAIN_W-1:0]         gain_step,
  output logic                      gain_valid,
  output logic [BIAS_W-1:0]         bias_level,
  output logic                      bias_valid,
  output logic                      bias_advised
);

  // ==========================================================
  // System-side state
  typedef struct packed {
    logic [1:0]          req_sync;
    logic                req_seen;
    logic                ack_tgl;
    logic [1:0]          sel_sync;
    logic [1:0]          swap_sync;
    logic [1:0]          init_cnt;
    logic [7:0]          ctrl_shadow;
    logic [7:0]          ctrl_active;
    logic [NUM_TRIG-1:0] trig_mask;
    logic                trig_en;
    logic [USID_W-1:0]   usid;
    logic                transfer;
    logic                amp_on;
    logic [GAIN_W-1:0]   gain_step;
    logic                gain_valid;
    logic [BIAS_W-1:0]   bias_level;
    logic                bias_valid;
    logic                bias_advised;
  } sys_state_t;

  sys_state_t q;
  sys_state_t d;

  // Merge a masked write into an old byte
  function automatic logic [7:0] merge_masked(
    input logic [7:0] old_val,
    input logic [7:0] wr_val,
    input logic [7:0] wr_en
  );
    merge_masked = (old_val & ~wr_en) | (wr_val & wr_en);
  endfunction

  // ==========================================================
  // Link-side capture and crossing
  logic       req_tgl;
  logic [7:0] held_addr;
  logic [7:0] held_data;
  logic [7:0] held_mask;

  // Holds each write on the link clock until acknowledged
  lna_link_capture u_link (
    .sclk       (sclk),
    .link_rst   (link_rst),
    .wr_valid   (wr_valid),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .wr_mask    (wr_mask),
    .ack_tgl    (q.ack_tgl),
    .link_ready (link_ready),
    .req_tgl    (req_tgl),
    .held_addr  (held_addr),
    .held_data  (held_data),
    .held_mask  (held_mask)
  );

  // New write seen; held words are stable until the ack returns
  logic                       take;
  logic [NUM_STROBE_TRIG-1:0] ext_fire;
  assign take     = ce && (q.req_sync[1] != q.req_seen);
  assign ext_fire = held_data & held_mask;

  // ==========================================================
  // Control byte decode
  logic              dec_amp_on;
  logic [GAIN_W-1:0] dec_gain_step;
  logic              dec_gain_valid;
  logic [BIAS_W-1:0] dec_bias_level;
  logic              dec_bias_valid;
  logic              dec_bias_advised;

  // Gain, bias and advice from the active byte
  lna_mode_decoder u_dec (
    .ctrl         (q.ctrl_active),
    .gain_prev    (q.gain_step),
    .bias_prev    (q.bias_level),
    .amp_on       (dec_amp_on),
    .gain_step    (dec_gain_step),
    .gain_valid   (dec_gain_valid),
    .bias_level   (dec_bias_level),
    .bias_valid   (dec_bias_valid),
    .bias_advised (dec_bias_advised)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [NUM_TRIG-1:0] fire;
    logic [7:0]          merged;
    fire   = '0;
    merged = 8'h00;
    d      = q;
    if (ce) begin
      d.req_sync  = {q.req_sync[0], req_tgl};
      d.req_seen  = q.req_sync[1];
      d.sel_sync  = {q.sel_sync[0], usid_sel_pin};
      d.swap_sync = {q.swap_sync[0], line_swap};
      d.transfer  = 1'b0;
      // Catch the identifier straps once the pins are synchronised
      if (q.init_cnt != 2'h0) begin
        d.init_cnt = q.init_cnt - 2'h1;
        if (q.init_cnt == USID_INIT_ONE) begin
          d.usid = {USID_UPPER, q.swap_sync[1], q.sel_sync[1]};
        end
      end
      if (take) begin
        d.ack_tgl = ~q.ack_tgl;
        unique case (held_addr)
          ADDR_CTRL: begin
            d.ctrl_shadow = merge_masked(q.ctrl_shadow, held_data,
                                         held_mask);
            if (!q.trig_en) begin
              d.ctrl_active = d.ctrl_shadow;
            end
          end
          ADDR_PM_TRIG: begin
            merged = merge_masked({5'h00, q.trig_mask[NUM_PM_TRIG-1:0]},
                                  held_data >> PM_MASK_LSB,
                                  held_mask >> PM_MASK_LSB);
            d.trig_mask[NUM_PM_TRIG-1:0] = merged[NUM_PM_TRIG-1:0];
            fire[NUM_PM_TRIG-1:0] = ext_fire[NUM_PM_TRIG-1:0];
          end
          ADDR_EXT_MASK: begin
            d.trig_mask[NUM_TRIG-1:NUM_PM_TRIG] = merge_masked(
              q.trig_mask[NUM_TRIG-1:NUM_PM_TRIG], held_data,
              held_mask);
          end
          ADDR_STROBE: begin
            fire[NUM_TRIG-1:NUM_PM_TRIG] = ext_fire;
          end
          ADDR_USID: begin
            merged = merge_masked({4'h0, q.usid}, held_data, held_mask);
            d.usid = merged[USID_W-1:0];
          end
          ADDR_BEHAVIOUR: begin
            merged = merge_masked({7'h00, q.trig_en}, held_data,
                                  held_mask >> BEHAV_TRIG_EN_BIT);
            d.trig_en = merged[0];
          end
          default: begin
          end
        endcase
        // Unmasked trigger moves the shadow into the active byte
        if (q.trig_en && |(fire & q.trig_mask)) begin
          d.ctrl_active = q.ctrl_shadow;
          d.transfer    = 1'b1;
        end
      end
      // Registered decode of the active byte
      d.amp_on       = dec_amp_on;
      d.gain_step    = dec_gain_step;
      d.gain_valid   = dec_gain_valid;
      d.bias_level   = dec_bias_level;
      d.bias_valid   = dec_bias_valid;
      d.bias_advised = dec_bias_advised;
    end
  end

  // State register on the system clock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q             <= '0;
      q.ctrl_shadow <= CTRL_RESET;
      q.ctrl_active <= CTRL_RESET;
      q.trig_en     <= TRIG_EN_RESET;
      q.init_cnt    <= USID_INIT_WAIT;
      q.usid        <= USID_RESET;
      q.bias_level  <= BIAS_LEVEL_LOWEST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign ctrl_shadow   = q.ctrl_shadow;
  assign ctrl_active   = q.ctrl_active;
  assign trig_mask     = q.trig_mask;
  assign trig_enable   = q.trig_en;
  assign slave_id      = q.usid;
  assign transfer_done = q.transfer;
  assign amp_on        = q.amp_on;
  assign gain_step     = q.gain_step;
  assign gain_valid    = q.gain_valid;
  assign bias_level    = q.bias_level;
  assign bias_valid    = q.bias_valid;
  assign bias_advised  = q.bias_advised;

  // ==========================================================
  // Checks
  logic [GAIN_W-1:0] act_gain_code;
  logic [BIAS_W-1:0] act_bias_code;
  assign act_gain_code = q.ctrl_active[GAIN_LSB +: GAIN_W];
  assign act_bias_code = q.ctrl_active[BIAS_LSB +: BIAS_W];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Zero in the trigger byte leaves the active byte alone
  a_zero_no_copy: assert property (
    take && held_addr == ADDR_STROBE && ext_fire == 8'h00
    |=> $stable(q.ctrl_active) && !q.transfer)
    else $error("zero trigger write changed active control");

  // Unmasked trigger copies the shadow byte next cycle
  a_trig_copies: assert property (
    take && held_addr == ADDR_STROBE && q.trig_en
    && |(ext_fire & q.trig_mask[NUM_TRIG-1:NUM_PM_TRIG])
    |=> q.ctrl_active == $past(q.ctrl_shadow) && q.transfer)
    else $error("trigger did not copy shadow to active");

  // Identifier strap caught after synchronisation
  a_usid_strap: assert property (
    ce && q.init_cnt == USID_INIT_ONE
    |=> q.usid == {USID_UPPER, $past(q.swap_sync[1]),
                   $past(q.sel_sync[1])})
    else $error("default identifier not taken from straps");

  // Amplifier on follows control bit seven
  a_amp_follows: assert property (
    ce |=> q.amp_on == $past(q.ctrl_active[CTRL_ON_BIT]))
    else $error("amplifier enable does not follow control bit");

  // Gain step is the code less one
  a_gain_map: assert property (
    ce && act_gain_code != GAIN_CODE_NONE
    |=> q.gain_valid
    && q.gain_step == $past(act_gain_code) - GAIN_CODE_OFFSET)
    else $error("gain step decode wrong");

  // Legal bias codes map straight to levels
  a_bias_map: assert property (
    ce && act_bias_code <= BIAS_LEVEL_HIGHEST
    |=> q.bias_valid && q.bias_level == $past(act_bias_code))
    else $error("bias level decode wrong");

  // Mid gains advised only at bias two
  a_advice_mid: assert property (
    q.bias_advised && q.gain_step > GAIN_STEP_LOW_TOP
    && q.gain_step != GAIN_STEP_BYPASS
    |-> q.bias_level == BIAS_FOR_MID_GAIN)
    else $error("mid gain advice flag wrong");

  // High gains advised only at bias six
  a_advice_high: assert property (
    q.bias_advised && q.gain_step <= GAIN_STEP_LOW_TOP
    |-> q.bias_level == BIAS_FOR_HIGH_GAIN)
    else $error("high gain advice flag wrong");

  // Masked triggers leave the active byte held
  a_mask_holds: assert property (
    take && held_addr == ADDR_STROBE
    && (ext_fire & q.trig_mask[NUM_TRIG-1:NUM_PM_TRIG]) == 8'h00
    |=> $stable(q.ctrl_active))
    else $error("masked trigger moved shadow data");

  // Control and masks start cleared
  a_ctrl_reset: assert property (
    $fell(sys_rst) |-> q.ctrl_active == CTRL_RESET
    && q.trig_mask == '0 && !q.amp_on)
    else $error("control not cleared by reset");

  // Full identifier write replaces the default
  a_usid_write: assert property (
    take && held_addr == ADDR_USID && held_mask[USID_W-1:0] == 4'hF
    |=> q.usid == $past(held_data[USID_W-1:0]))
    else $error("identifier write not applied");

  // Triggers on after reset; writes go direct when off
  a_trig_default: assert property (
    $fell(sys_rst) |-> q.trig_en)
    else $error("triggers not enabled after reset");

  a_direct_write: assert property (
    take && held_addr == ADDR_CTRL && !q.trig_en && held_mask == 8'hFF
    |=> q.ctrl_active == $past(held_data))
    else $error("direct control write not applied");

  // Reserved bias codes flagged and level held
  a_bias_reserved: assert property (
    ce && act_bias_code > BIAS_LEVEL_HIGHEST
    |=> !q.bias_valid && $stable(q.bias_level))
    else $error("reserved bias code not flagged");

endmodule
`default_nettype wire

// File: verilog/lna_regs_pkg.sv
package lna_regs_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_CTRL      = 8'h01;
  localparam logic [7:0] ADDR_PM_TRIG   = 8'h1C;
  localparam logic [7:0] ADDR_USID      = 8'h1F;
  localparam logic [7:0] ADDR_EXT_MASK  = 8'h2D;
  localparam logic [7:0] ADDR_STROBE    = 8'h2E;
  localparam logic [7:0] ADDR_BEHAVIOUR = 8'h2F;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] STROBE_RESET   = 8'h00;
  localparam logic       TRIG_EN_RESET  = 1'b1;
  localparam logic [1:0] USID_UPPER     = 2'h2;
  localparam logic [3:0] USID_RESET     = 4'h8;
  localparam logic [1:0] USID_INIT_WAIT = 2'h3;
  localparam logic [1:0] USID_INIT_ONE  = 2'h1;

  // ==========================================================
  // Field layout
  localparam int NUM_TRIG          = 11;
  localparam int NUM_PM_TRIG       = 3;
  localparam int NUM_STROBE_TRIG   = 8;
  localparam int PM_MASK_LSB       = 3;
  localparam int CTRL_ON_BIT       = 7;
  localparam int GAIN_LSB          = 4;
  localparam int GAIN_W            = 3;
  localparam int BIAS_LSB          = 0;
  localparam int BIAS_W            = 4;
  localparam int USID_W            = 4;
  localparam int BEHAV_TRIG_EN_BIT = 0;

  // ==========================================================
  // Gain and bias codes
  localparam logic [2:0] GAIN_CODE_NONE     = 3'h0;
  localparam logic [2:0] GAIN_CODE_OFFSET   = 3'h1;
  localparam logic [2:0] GAIN_STEP_LOW_TOP  = 3'h1;
  localparam logic [2:0] GAIN_STEP_BYPASS   = 3'h6;
  localparam logic [3:0] BIAS_LEVEL_LOWEST  = 4'h0;
  localparam logic [3:0] BIAS_LEVEL_HIGHEST = 4'hA;
  localparam logic [3:0] BIAS_FOR_MID_GAIN  = 4'h2;
  localparam logic [3:0] BIAS_FOR_HIGH_GAIN = 4'h6;

endpackage

// File: verilog/lna_mode_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module lna_mode_decoder
  import lna_regs_pkg::*;
(
  input  wire logic [7:0]        ctrl,
  input  wire logic [GAIN_W-1:0] gain_prev,
  input  wire logic [BIAS_W-1:0] bias_prev,
  output logic                   amp_on,
  output logic [GAIN_W-1:0]      gain_step,
  output logic                   gain_valid,
  output logic [BIAS_W-1:0]      bias_level,
  output logic                   bias_valid,
  output logic                   bias_advised
);

  // ==========================================================
  // Control byte decode
  logic [GAIN_W-1:0] gain_code;
  logic [BIAS_W-1:0] bias_code;

  // Fields, gain steps and bias levels
  always_comb begin
    gain_code  = ctrl[GAIN_LSB +: GAIN_W];
    bias_code  = ctrl[BIAS_LSB +: BIAS_W];
    amp_on     = ctrl[CTRL_ON_BIT];
    gain_valid = (gain_code != GAIN_CODE_NONE);
    gain_step  = gain_valid ? gain_code - GAIN_CODE_OFFSET
                            : gain_prev;
    bias_valid = (bias_code <= BIAS_LEVEL_HIGHEST);
    bias_level = bias_valid ? bias_code : bias_prev;
    // Check bias against the recommended level per gain step
    if (!gain_valid || !bias_valid) begin
      bias_advised = 1'b0;
    end else if (gain_step == GAIN_STEP_BYPASS) begin
      bias_advised = 1'b1;
    end else if (gain_step <= GAIN_STEP_LOW_TOP) begin
      bias_advised = (bias_level == BIAS_FOR_HIGH_GAIN);
    end else begin
      bias_advised = (bias_level == BIAS_FOR_MID_GAIN);
    end
  end

endmodule
`default_nettype wire

// File: verilog/lna_link_capture.sv
`timescale 1ns/1ps
`default_nettype none
module lna_link_capture
  import lna_regs_pkg::*;
(
  input  wire logic       sclk,
  input  wire logic       link_rst,
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] wr_mask,
  input  wire logic       ack_tgl,
  output logic            link_ready,
  output logic            req_tgl,
  output logic [7:0]      held_addr,
  output logic [7:0]      held_data,
  output logic [7:0]      held_mask
);

  // ==========================================================
  // Link-side state
  typedef struct packed {
    logic       req_tgl;
    logic [1:0] ack_sync;
    logic       ready;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] mask;
  } link_state_t;

  link_state_t q;
  link_state_t d;

  // Hold one write and toggle the request toward the system side
  always_comb begin
    d          = q;
    d.ack_sync = {q.ack_sync[0], ack_tgl};
    if (wr_valid && q.ready) begin
      d.addr    = wr_addr;
      d.data    = wr_data;
      d.mask    = wr_mask;
      d.req_tgl = ~q.req_tgl;
    end
    d.ready = (d.req_tgl == q.ack_sync[1]);
  end

  // State register on the link clock
  always_ff @(posedge sclk) begin
    if (link_rst) begin
      q       <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign link_ready = q.ready;
  assign req_tgl    = q.req_tgl;
  assign held_addr  = q.addr;
  assign held_data  = q.data;
  assign held_mask  = q.mask;

endmodule
`default_nettype wire

// File: test/rffe_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module rffe_master_model
  import lna_regs_pkg::*;
(
  output logic       sclk,
  input  wire logic  link_ready,
  output logic       wr_valid,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] wr_mask
);
  logic run;
  int   timeouts;

  // ==========================================================
  // Link clock, still outside frames
  initial begin
    run      = 1'b1;
    timeouts = 0;
    sclk     = 1'b0;
    wr_valid = 1'b0;
    wr_addr  = 8'h00;
    wr_data  = 8'h00;
    wr_mask  = 8'h00;
    #2.7;
    forever #6 if (run) sclk = ~sclk;
  end

  // ==========================================================
  // Recommended bias for a gain step
  function automatic logic [3:0] advised_bias(input logic [2:0] step);
    if (step <= GAIN_STEP_LOW_TOP) return BIAS_FOR_HIGH_GAIN;
    return BIAS_FOR_MID_GAIN;
  endfunction

  // ==========================================================
  // One write, held until taken, then lines inverted
  task automatic write(input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] m);
    int   n;
    logic low_seen;
    run      = 1'b1;
    low_seen = 1'b0;
    n        = 0;
    do begin
      @(posedge sclk);
      #1;
      n++;
    end while (link_ready !== 1'b1 && n < 50);
    if (link_ready !== 1'b1) timeouts++;
    wr_valid = 1'b1;
    wr_addr  = a;
    wr_data  = d;
    wr_mask  = m;
    @(posedge sclk);
    #1;
    wr_valid = 1'b0;
    wr_addr  = ~a;
    wr_data  = ~d;
    wr_mask  = ~m;
    n        = 0;
    while (!(low_seen && link_ready === 1'b1) && n < 60) begin
      if (link_ready !== 1'b1) low_seen = 1'b1;
      @(posedge sclk);
      #1;
      n++;
    end
    if (!(low_seen && link_ready === 1'b1)) timeouts++;
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/lna_gain_bias_trigger_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lna_gain_bias_trigger_regs_bench
  import lna_regs_pkg::*;
;
  logic                clk_sys, sys_rst, ce, sclk, link_rst;
  logic                wr_valid, usid_sel_pin, line_swap;
  logic [7:0]          wr_addr, wr_data, wr_mask;
  logic                link_ready, trig_enable, transfer_done, amp_on;
  logic [7:0]          ctrl_shadow, ctrl_active, c, prev;
  logic [NUM_TRIG-1:0] trig_mask;
  logic [USID_W-1:0]   slave_id;
  logic [GAIN_W-1:0]   gain_step, exp_gain;
  logic [BIAS_W-1:0]   bias_level, exp_bias;
  logic                gain_valid, bias_valid, bias_advised, done_seen;
  int                  bad_count, tests_run, cycles;

  lna_gain_bias_trigger_regs u_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .sclk(sclk),
    .link_rst(link_rst), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_mask(wr_mask), .usid_sel_pin(usid_sel_pin),
    .line_swap(line_swap), .link_ready(link_ready),
    .ctrl_shadow(ctrl_shadow), .ctrl_active(ctrl_active),
    .trig_mask(trig_mask), .trig_enable(trig_enable), .slave_id(slave_id),
    .transfer_done(transfer_done), .amp_on(amp_on), .gain_step(gain_step),
    .gain_valid(gain_valid), .bias_level(bias_level),
    .bias_valid(bias_valid), .bias_advised(bias_advised)
  );

  rffe_master_model u_master (
    .sclk(sclk), .link_ready(link_ready), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask(wr_mask)
  );

  // ==========================================================
  // Clock, timeout and trigger pulse catcher
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (transfer_done === 1'b1) done_seen <= 1'b1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [10:0] exp,
                     input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] m);
    u_master.write(a, d, m);
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_mode(input logic [7:0] v);
    logic gv, bv, adv;
    gv = v[6:4] != 3'h0;
    bv = v[3:0] <= BIAS_LEVEL_HIGHEST;
    if (gv) exp_gain = v[6:4] - 3'h1;
    if (bv) exp_bias = v[3:0];
    adv = gv && bv && (exp_gain == GAIN_STEP_BYPASS ||
          exp_bias == ((exp_gain <= 3'h1) ? 4'h6 : 4'h2));
    chk("amp_on", v[7], amp_on);
    chk("gain_step", exp_gain, gain_step);
    chk("gain_valid", gv, gain_valid);
    chk("bias_level", exp_bias, bias_level);
    chk("bias_valid", bv, bias_valid);
    chk("bias_advised", adv, bias_advised);
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {sys_rst, link_rst, ce, usid_sel_pin, line_swap} = 5'b11100;
    {bad_count, tests_run, cycles} = '0;
    {done_seen, exp_gain, exp_bias, prev} = '0;
    // Strap identifier for each pin and swap level
    for (int i = 0; i < 4; i++) begin
      u_master.run = 1'b1;
      @(posedge clk_sys);
      #1;
      {line_swap, usid_sel_pin} = 2'(i);
      {sys_rst, link_rst} = 2'b11;
      repeat (5) @(posedge clk_sys);
      #1;
      {sys_rst, link_rst} = 2'b00;
      repeat (6) @(posedge clk_sys);
      #1;
      chk("slave_id", {USID_UPPER, 2'(i)}, slave_id);
    end
    chk("ctrl_shadow", CTRL_RESET, ctrl_shadow);
    chk("ctrl_active", CTRL_RESET, ctrl_active);
    chk("trig_mask", 11'h000, trig_mask);
    chk("trig_enable", 1'b1, trig_enable);
    chk("transfer_done", 1'b0, transfer_done);
    chk("amp_on", 1'b0, amp_on);
    $display("Test reset done");
    wr(ADDR_USID, 8'h05, 8'hFF);
    chk("slave_id", 4'h5, slave_id);
    $display("Test identifier done");
    // Each extended trigger, masked then unmasked
    for (int t = 0; t < NUM_STROBE_TRIG; t++) begin
      c = {1'b1, 3'(t), (t == 0) ? 4'h0 : u_master.advised_bias(3'(t - 1))};
      wr(ADDR_EXT_MASK, 8'h01 << t, 8'hFF);
      wr(ADDR_CTRL, c, 8'hFF);
      chk("ctrl_shadow", c, ctrl_shadow);
      chk("ctrl_active", prev, ctrl_active);
      done_seen = 1'b0;
      wr(ADDR_STROBE, ~(8'h01 << t), 8'hFF);
      chk("ctrl_active", prev, ctrl_active);
      chk("transfer_done", 1'b0, done_seen);
      wr(ADDR_STROBE, 8'h01 << t, 8'hFF);
      chk("ctrl_active", c, ctrl_active);
      chk("transfer_done", 1'b1, done_seen);
      chk("trig_mask", {8'h01 << t, 3'h0}, trig_mask);
      chk_mode(c);
      prev = c;
    end
    $display("Test extended triggers done");
    wr(ADDR_CTRL, 8'h05, 8'h0F);
    chk("ctrl_shadow", {prev[7:4], 4'h5}, ctrl_shadow);
    wr(ADDR_PM_TRIG, 8'h38, 8'h38);
    chk("trig_mask", {8'h80, 3'h7}, trig_mask);
    wr(ADDR_PM_TRIG, 8'h01, 8'h01);
    chk("ctrl_active", {prev[7:4], 4'h5}, ctrl_active);
    wr(8'h40, 8'hFF, 8'hFF);
    chk("ctrl_shadow", {prev[7:4], 4'h5}, ctrl_shadow);
    $display("Test masked and unmapped done");
    // Direct updates with triggers off, every gain and bias code
    wr(ADDR_BEHAVIOUR, 8'h00, 8'hFF);
    chk("trig_enable", 1'b0, trig_enable);
    for (int b = 0; b < 16; b++) begin
      c = {1'b1, 3'(b % 8), 4'(b)};
      wr(ADDR_CTRL, c, 8'hFF);
      chk("ctrl_active", c, ctrl_active);
      chk_mode(c);
    end
    wr(ADDR_CTRL, 8'h00, 8'hFF);
    chk("amp_on", 1'b0, amp_on);
    wr(ADDR_BEHAVIOUR, 8'h01, 8'hFF);
    chk("trig_enable", 1'b1, trig_enable);
    wr(ADDR_CTRL, 8'hFF, 8'hFF);
    chk("ctrl_active", 8'h00, ctrl_active);
    $display("Test direct decode done");
    // Clock enable low freezes the system side mid-write
    ce = 1'b0;
    fork
      wr(ADDR_CTRL, 8'h3C, 8'hFF);
      begin
        repeat (20) @(posedge clk_sys);
        #1;
        chk("ctrl_shadow", 8'hFF, ctrl_shadow);
        ce = 1'b1;
      end
    join
    chk("ctrl_shadow", 8'h3C, ctrl_shadow);
    chk("write_timeouts", 11'h000, 11'(u_master.timeouts));
    $display("Test clock enable done");
    results();
  end
endmodule
`default_nettype wire
